// File: analog_frequency_reference_scaler.sv
// Analog speed input to drive frequency reference scaler
// Assumes inputs synchronous to SYS_CLK and a master that never waits
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "freq_scaler_regs.svh"

module analog_frequency_reference_scaler
	import freq_scaler_pkg::*;
#(
	parameter int ADDR_W = 5,
	parameter int IN_W = 16
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic [IN_W-1:0] VOLTAGE_ANALOG_INPUT,
	input wire logic [IN_W-1:0] CURRENT_ANALOG_INPUT,
	output logic [15:0] FREQ_REF,
	output logic REVERSE
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 5) begin : g_addr_chk
		$error("ADDR_W must be at least 5");
	end
	if (IN_W < 14 || IN_W > 16) begin : g_in_chk
		$error("IN_W must lie in 14..16");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`NUM_RW_REGS-1:0][15:0] regs;
		word_t rdata;
		freq_out_t out;
	} state_t;

	state_t state_q;
	state_t state_d;

	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------
	function automatic logic signed [31:0] abs32(input logic signed [31:0] v);
		abs32 = (v < 0) ? -v : v;
	endfunction : abs32

	function automatic logic signed [31:0] sx(input word_t w);
		sx = {{16{w[15]}}, w};
	endfunction : sx

	// Breakpoint inputs are unsigned in 0.01 % of full scale
	function automatic logic signed [31:0] ux(input word_t w);
		ux = {16'h0000, w};
	endfunction : ux

	// Percent in 0.1 % units at input x on a three-point curve
	function automatic logic signed [31:0] interp(
		input logic signed [31:0] x,
		input logic signed [31:0] x0,
		input logic signed [31:0] p0,
		input logic signed [31:0] x1,
		input logic signed [31:0] p1
	);
		// Degenerate segment holds the left value to avoid a zero divide
		if (x1 <= x0) begin
			interp = p0;
		end else begin
			interp = p0 + ((p1 - p0) * (x - x0)) / (x1 - x0);
		end
	endfunction : interp

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	logic [1:0] curve;
	logic permit;
	logic src_analog;
	logic use_current;
	logic [1:0] pol;
	logic signed [31:0] ain;
	logic signed [31:0] bias;
	logic signed [31:0] gain_term;
	logic signed [31:0] pct_line;
	logic signed [31:0] pct_curve;
	logic signed [31:0] pct;
	logic signed [31:0] freq_s;
	logic signed [31:0] mag;
	logic signed [31:0] maxf;
	logic signed [31:0] trim;
	logic rev;
	logic [4:0] pbase;
	logic signed [31:0] x0;
	logic signed [31:0] x1;
	logic signed [31:0] x2;
	logic signed [31:0] p0;
	logic signed [31:0] p1;
	logic signed [31:0] p2;

	always_comb begin
		curve = state_q.regs[`REG_CTRL][`CTRL_CURVE_LSB +: 2];
		permit = state_q.regs[`REG_CTRL][`CTRL_PERMIT_BIT];
		src_analog = state_q.regs[`REG_CTRL][`CTRL_SRC_ANALOG_BIT];
		// Curve 1 forces voltage, curve 2 forces current; code 3 acts as normal
		use_current = (curve == `CURVE_CURRENT) ||
			(curve != `CURVE_VOLTAGE && state_q.regs[`REG_CTRL][`CTRL_USE_CURRENT_BIT]);
		ain = use_current ? {{(32-IN_W){1'b0}}, CURRENT_ANALOG_INPUT} :
			{{(32-IN_W){1'b0}}, VOLTAGE_ANALOG_INPUT};
		if (ain > `IN_FULL) begin
			ain = `IN_FULL;
		end
		maxf = ux(state_q.regs[`REG_MAX_FREQ]);
		trim = ux(state_q.regs[`REG_TRIM_FREQ]);

		// Bias and gain line
		if (use_current) begin
			pol = state_q.regs[`REG_CTRL][`CTRL_C_POL_LSB +: 2];
			bias = sx(state_q.regs[`REG_C_BIAS]);
			gain_term = (sx(state_q.regs[`REG_C_GAIN]) * ain) / `IN_FULL;
		end else begin
			pol = state_q.regs[`REG_CTRL][`CTRL_V_POL_LSB +: 2];
			bias = sx(state_q.regs[`REG_V_BIAS]);
			gain_term = (sx(state_q.regs[`REG_V_GAIN]) * ain) / `IN_FULL;
		end
		case (pol)
			`POL_GE: pct_line = bias - gain_term;
			`POL_ABS: pct_line = gain_term - abs32(bias);
			default: pct_line = bias + gain_term;
		endcase

		// Three-point curve
		pbase = (curve == `CURVE_CURRENT) ? `REG_C_POINTS : `REG_V_POINTS;
		x0 = ux(state_q.regs[pbase]);
		p0 = sx(state_q.regs[pbase + 5'h01]);
		x1 = ux(state_q.regs[pbase + 5'h02]);
		p1 = sx(state_q.regs[pbase + 5'h03]);
		x2 = ux(state_q.regs[pbase + 5'h04]);
		p2 = sx(state_q.regs[pbase + 5'h05]);
		// Low and mid at 0 % hold zero up to the mid input
		if (ain <= x0) begin
			pct_curve = p0;
		end else if (ain <= x1) begin
			pct_curve = interp(ain, x0, p0, x1, p1);
		end else if (ain <= x2) begin
			pct_curve = interp(ain, x1, p1, x2, p2);
		end else begin
			pct_curve = p2;
		end

		if (curve == `CURVE_VOLTAGE || curve == `CURVE_CURRENT) begin
			pct = pct_curve;
		end else begin
			pct = pct_line;
		end

		freq_s = (pct * maxf) / `PCT_FULL;
		// Negative result folds to its magnitude unless reverse is allowed
		rev = (freq_s < 0) && src_analog && (permit == `PERMIT_NEG);
		mag = abs32(freq_s);
		if (mag > maxf) begin
			mag = maxf;
		end
		// Trim floors at zero rather than flipping direction
		if (state_q.regs[`REG_TRIM_SEL] == `TRIM_SUBTRACT) begin
			mag = (mag > trim) ? mag - trim : 32'sd0;
		end
		if (mag == 0) begin
			rev = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register port and next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		if (CE) begin
			state_d.out.freq = mag[15:0];
			state_d.out.reverse = rev;
			if (WR && ADDR < ADDR_W'(`NUM_RW_REGS)) begin
				state_d.regs[ADDR[4:0]] = WDATA;
			end
			if (RD) begin
				if (ADDR < ADDR_W'(`NUM_RW_REGS)) begin
					state_d.rdata = state_q.regs[ADDR[4:0]];
				end else if (ADDR == ADDR_W'(`REG_STAT_FREQ)) begin
					state_d.rdata = state_q.out.freq;
				end else if (ADDR == ADDR_W'(`REG_STAT_DIR)) begin
					state_d.rdata = {15'h0000, state_q.out.reverse};
				end else begin
					// Unmapped reads return zero
					state_d.rdata = 16'h0000;
				end
			end else begin
				// Read data stands for one cycle only
				state_d.rdata = 16'h0000;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_q <= '0;
			state_q.regs[`REG_CTRL] <= `RST_CTRL;
			state_q.regs[`REG_V_GAIN] <= `RST_GAIN;
			state_q.regs[`REG_C_GAIN] <= `RST_GAIN;
			state_q.regs[`REG_MAX_FREQ] <= `RST_MAX_FREQ;
			state_q.regs[`REG_V_POINTS + 5'h02] <= `RST_MID_IN;
			state_q.regs[`REG_V_POINTS + 5'h03] <= `RST_MID_PCT;
			state_q.regs[`REG_V_POINTS + 5'h04] <= `RST_HIGH_IN;
			state_q.regs[`REG_V_POINTS + 5'h05] <= `RST_HIGH_PCT;
			state_q.regs[`REG_C_POINTS + 5'h02] <= `RST_MID_IN;
			state_q.regs[`REG_C_POINTS + 5'h03] <= `RST_MID_PCT;
			state_q.regs[`REG_C_POINTS + 5'h04] <= `RST_HIGH_IN;
			state_q.regs[`REG_C_POINTS + 5'h05] <= `RST_HIGH_PCT;
		end else begin
			state_q <= state_d;
		end
	end

	assign RDATA = state_q.rdata;
	assign FREQ_REF = state_q.out.freq;
	assign REVERSE = state_q.out.reverse;

endmodule : analog_frequency_reference_scaler

// File: freq_scaler_pkg.sv
// Types shared by the frequency reference scaler
// Assumes the register header is compiled alongside
package freq_scaler_pkg;

	typedef logic [15:0] word_t;

	typedef struct packed {
		logic [4:0] addr;
		word_t wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		word_t freq;
		logic reverse;
	} freq_out_t;

endpackage : freq_scaler_pkg

// File: freq_scaler_regs.svh
// Register offsets, field positions, reset values and scaling constants
// Assumes a 16-bit word register port with word addresses
//
// Overview of operation
// - Curve zero uses bias and gain line
// - Curve 1 voltage, 2 current three-point
// - Zero low and mid points give zero up to the mid input
// - Reverse only from analog source with permit
// - Permit zero folds negative result to magnitude
// - Permit encoding: 0 none, 1 allowed
// - Bias modes 0 none, 2 inverse, 3 absolute
// - Trim select 4 subtracts trim reference
// - Full bias, mode 2 gives inverse mapping
`ifndef FREQ_SCALER_REGS_SVH
`define FREQ_SCALER_REGS_SVH

// ----------------------------------------------------------------
// Register indices (word addresses)
// ----------------------------------------------------------------
`define REG_CTRL 5'h00
`define REG_V_BIAS 5'h01
`define REG_C_BIAS 5'h02
`define REG_V_GAIN 5'h03
`define REG_C_GAIN 5'h04
`define REG_V_POINTS 5'h05
`define REG_C_POINTS 5'h0b
`define REG_TRIM_SEL 5'h11
`define REG_TRIM_FREQ 5'h12
`define REG_MAX_FREQ 5'h13
`define REG_STAT_FREQ 5'h14
`define REG_STAT_DIR 5'h15
`define NUM_RW_REGS 20

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_CURVE_LSB 0
`define CTRL_PERMIT_BIT 2
`define CTRL_SRC_ANALOG_BIT 3
`define CTRL_USE_CURRENT_BIT 4
`define CTRL_V_POL_LSB 5
`define CTRL_C_POL_LSB 7

// ----------------------------------------------------------------
// Codes and scales
// ----------------------------------------------------------------
`define CURVE_NORMAL 2'h0
`define CURVE_VOLTAGE 2'h1
`define CURVE_CURRENT 2'h2
`define POL_NONE 2'h0
`define POL_GE 2'h2
`define POL_ABS 2'h3
`define PERMIT_NONE 1'h0
`define PERMIT_NEG 1'h1
`define TRIM_SUBTRACT 16'h0004
`define PCT_FULL 32'sd1000
`define IN_FULL 32'sd10000

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CTRL 16'h0008
`define RST_GAIN 16'h03e8
`define RST_MAX_FREQ 16'h1770
`define RST_MID_IN 16'h1388
`define RST_MID_PCT 16'h01f4
`define RST_HIGH_IN 16'h2710
`define RST_HIGH_PCT 16'h03e8

`endif

// File: scaler_props.sv
// Port assertions for the frequency reference scaler
// Assumes bind to the scaler top and the register reset values
`timescale 1ns/10ps
module scaler_props
	import freq_scaler_pkg::*;
#(
	parameter int ADDR_W = 5,
	parameter int IN_W = 16
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic [IN_W-1:0] VOLTAGE_ANALOG_INPUT,
	input wire logic [IN_W-1:0] CURRENT_ANALOG_INPUT,
	input wire logic [15:0] FREQ_REF,
	input wire logic REVERSE
);
	// ----------------------------------------
	// Shadow of control and maximum
	// ----------------------------------------
	logic [15:0] ctl_q;
	logic [15:0] max_q;
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ctl_q <= 16'h0008;
			max_q <= 16'h1770;
		end else if (CE && WR) begin
			if (ADDR == 5'h00) ctl_q <= WDATA;
			if (ADDR == 5'h13) max_q <= WDATA;
		end
	end
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	a_rdata_idle: assert property ($past(CE) && !$past(RD) |-> RDATA == 16'h0000)
		else $error("read data not idle");
	a_unmapped_zero: assert property (CE && RD && ADDR > 5'h15 |=> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_status_freq: assert property (CE && RD && ADDR == 5'h14 |=> RDATA == $past(FREQ_REF))
		else $error("frequency status wrong");
	a_status_dir: assert property (CE && RD && ADDR == 5'h15 |=> RDATA == {15'h0000, $past(REVERSE)})
		else $error("direction status wrong");
	a_ce_freeze: assert property (!CE |=> $stable(FREQ_REF) && $stable(REVERSE) && $stable(RDATA))
		else $error("state moved with enable low");
	a_freq_clamp: assert property (FREQ_REF <= $past(max_q))
		else $error("frequency above maximum");
	a_reverse_gate: assert property (!$past(ctl_q[3] && ctl_q[2]) |-> !REVERSE)
		else $error("reverse without permit");
	a_reverse_nonzero: assert property (REVERSE |-> FREQ_REF != 16'h0000)
		else $error("reverse at zero frequency");
	cover property (CE && RD && ADDR == 5'h14);
	cover property (REVERSE);
	cover property (FREQ_REF == max_q);
endmodule : scaler_props

bind analog_frequency_reference_scaler scaler_props #(.ADDR_W(ADDR_W), .IN_W(IN_W)) scaler_props_inst (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .VOLTAGE_ANALOG_INPUT(VOLTAGE_ANALOG_INPUT),
	.CURRENT_ANALOG_INPUT(CURRENT_ANALOG_INPUT), .FREQ_REF(FREQ_REF), .REVERSE(REVERSE));

// File: test_analog_frequency_reference_scaler.sv
// Self-checking bench for the frequency reference scaler
// Assumes package, header and checker are compiled first
`timescale 1ns/10ps
module test_analog_frequency_reference_scaler;
	logic sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, rev;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000, vin = 16'h0000, cin = 16'h0000, rdata, freq;
	int n_errors = 0, comparisons = 0, r[20], r0[20], e, i, k;
	int unsigned x = 32'hb758;
	analog_frequency_reference_scaler analog_frequency_reference_scaler_inst (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .VOLTAGE_ANALOG_INPUT(vin), .CURRENT_ANALOG_INPUT(cin),
		.FREQ_REF(freq), .REVERSE(rev));
	initial forever #25 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic int xs();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x & 32'h7fffffff;
	endfunction : xs
	function automatic int sg(int j);
		return r[j] > 32767 ? r[j] - 65536 : r[j];
	endfunction : sg
	function automatic int ip(int v, int j);
		return sg(j + 1) + (sg(j + 3) - sg(j + 1)) * (v - r[j]) / (r[j + 2] - r[j]);
	endfunction : ip
	function automatic int model(int v, int c);
		int u, p, g, b, f, m, rv;
		u = r[0][1:0] == 2 || (r[0][1:0] != 1 && r[0][4]);
		v = u ? c : v;
		if (v > 10000) v = 10000;
		if (r[0][1:0] == 1 || r[0][1:0] == 2) begin
			c = u ? 11 : 5;
			if (v <= r[c]) p = sg(c + 1);
			else if (v <= r[c + 2]) p = ip(v, c);
			else if (v <= r[c + 4]) p = ip(v, c + 2);
			else p = sg(c + 5);
		end else begin
			g = sg(3 + u) * v / 10000;
			b = sg(1 + u);
			c = (r[0] >> (u ? 7 : 5)) & 3;
			p = c == 2 ? b - g : c == 3 ? g - (b < 0 ? -b : b) : b + g;
		end
		f = p * r[19] / 1000;
		m = f < 0 ? -f : f;
		if (m > r[19]) m = r[19];
		rv = f < 0 && r[0][3] && r[0][2];
		if (r[17] == 4) m = m - r[18];
		if (m < 0) m = 0;
		return (rv && m > 0) * 65536 + m;
	endfunction : model
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wrr(int a, int d);
		@(posedge sys_clk);
		addr <= 5'(a);
		wdata <= 16'(d);
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		if (a < 20) r[a] = d & 16'hffff;
	endtask : wrr
	task automatic rdc(int a, int ex);
		@(posedge sys_clk);
		addr <= 5'(a);
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		chk("rdata", rdata, 16'(ex));
	endtask : rdc
	task automatic run(int v, int c);
		@(posedge sys_clk);
		vin <= 16'(v);
		cin <= 16'(c);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		e = model(v, c);
		chk("freq", freq, 16'(e));
		chk("rev", {15'h0000, rev}, 16'(e >> 16));
		rdc(20, e);
		rdc(21, e >> 16);
	endtask : run
	task automatic finish_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		finish_test();
	end
	initial begin
		r = '{8, 0, 0, 1000, 1000, 0, 0, 5000, 500, 10000, 1000, 0, 0, 5000, 500, 10000, 1000,
			0, 0, 6000};
		r0 = r;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 22; i++) rdc(i, i < 20 ? r[i] : 0);
		rdc(24, 0);
		// Full bias, inverse mode
		wrr(0, 16'h0048);
		wrr(1, 1000);
		run(0, 0);
		chk("inv", freq, 16'h1770);
		run(10000, 0);
		chk("inv", freq, 16'h0000);
		// Dead band below mid point
		wrr(0, 9);
		wrr(8, 0);
		wrr(10, 750);
		run(2500, 0);
		chk("dead", freq, 16'h0000);
		run(10000, 0);
		chk("top", freq, 16'h1194);
		// Random settings, ordered breakpoints
		for (i = 0; i < 60; i++) begin
			wrr(0, xs() & 16'h01ff);
			for (k = 1; k < 17; k++) wrr(k, k < 5 ? xs() % 2401 - 1200 : (k - 5) % 6 % 2 ?
				xs() % 2001 - 1000 : (k - 5) % 6 * 1500 + xs() % 3000);
			wrr(17, xs() % 2 ? 4 : xs() % 8);
			wrr(18, xs() % 3000);
			wrr(19, 1000 + xs() % 5000);
			repeat (3) run(xs() % 11000, xs() % 11000);
		end
		// Mid-run reset restores every default
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		r = r0;
		for (i = 0; i < 20; i++) rdc(i, r[i]);
		run(3000, 0);
		// Writes to status words are refused
		wrr(20, 16'h1234);
		rdc(20, e);
		// Enable low holds the output
		@(posedge sys_clk);
		ce <= 1'b0;
		vin <= ~vin;
		cin <= ~cin;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("hold", freq, 16'(e));
		@(posedge sys_clk);
		ce <= 1'b1;
		finish_test();
	end
endmodule : test_analog_frequency_reference_scaler
